//--- core/algo_debug_speed_source_select_reg.sv
// Algorithm debug speed_source_select register and its steering of the control path
// Function
// R1: Speed source select one takes speed command from written field.
// R2: Select zero takes speed command from analog, PWM or frequency input.
// R3: Bits 30..16 supply the 15-bit speed command when select is one.
// R4: Bit 15 set forces open loop commutation; clear keeps closed loop.
// R5: Bit 14 holds align state when startup is align or double align.
// R6: Bit 13 holds slow first cycle state when that startup is chosen.
// R7: Bit 12 holds position detect state when that startup is chosen.
// R8: Bit 11 holds speed detect state when speed detect is enabled.
// R9: Bit 10 picks align angle: configured zero, written forced angle one.
// R10: Bits 9..0 give torque reference when velocity loop off, signed mapping.
// R11: Software writes only codes 0..500 or 512..1000 in torque field.
// R12: Register is write-only and resets to all zeros.
// R13: Forced angle is 9 bits at 19..11 of device control, modulo 360.
// R14: Overrides sampled on each control update; no reset needed.
//
// Chosen here: the address-and-strobe port.
module algo_debug_speed_source_select_reg
  import algo_debug_pkg::*;
#(
  parameter int SPEED_WIDTH = SPEED_W
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  input wire logic ctrl_update, // Control update tick
  input wire logic [SPEED_WIDTH-1:0] pin_speed, // Speed from analog/PWM/freq
  input wire logic [ANGLE_W-1:0] cfg_align_angle, // Configured align angle
  input wire startup_method_e startup_method, // Configured startup method
  input wire logic initial_speed_detect_enable, // Speed detect enabled
  input wire logic velocity_loop_off, // Velocity loop disabled
  output logic [SPEED_WIDTH-1:0] speed_command, // Selected speed command
  output logic feedback_off, // Open loop commutation
  output logic hold_align_state, // Stay in align
  output logic hold_slow_state, // Stay in slow first cycle
  output logic hold_position_state, // Stay in position detect
  output logic hold_speed_state, // Stay in speed detect
  output logic [ANGLE_W-1:0] align_angle, // Applied align angle
  output logic torque_ref_valid, // Torque reference forced
  output torque_ref_s torque_ref // Torque reference, sign and code magnitude
);
  speed_source_select_s ovr;
  speed_source_select_s act;
  logic [ANGLE_W-1:0] forced_angle;
  logic [ANGLE_W-1:0] forced_angle_act;

  wire wr_ovr = ce && wr && (addr == OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT);
  wire wr_ang = ce && wr && (addr == OFS_DEVICE_ANGLE);

  // R12: reset zero, write-only storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovr <= speed_source_select_s'(RST_ALGO_DEBUG_SPEED_SOURCE_SELECT);
    end else if (wr_ovr) begin
      ovr <= speed_source_select_s'(wdata);
    end
  end

  // R13: forced angle field of device control
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      forced_angle <= '0;
    end else if (wr_ang) begin
      forced_angle <= wdata[POS_ANGLE_LSB +: ANGLE_W];
    end
  end

  // R14: take new settings on control update
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act <= speed_source_select_s'(RST_ALGO_DEBUG_SPEED_SOURCE_SELECT);
      forced_angle_act <= '0;
    end else if (ce && ctrl_update) begin
      act <= ovr;
      forced_angle_act <= forced_angle;
    end
  end

  // Write-only register reads zero; status word shows the active one-bit override flags, torque valid and torque sign
  wire [31:0] status_word = {23'h00_0000, act.speed_source_select, act.feedback_control_off,
    act.hold_align, act.hold_slow_first, act.hold_position_detect, act.hold_speed_detect,
    act.align_angle_source, torque_ref_valid, torque_ref.iq_negative};
  wire [31:0] next_rdata = (addr == OFS_SPEED_SOURCE_SELECT_STATUS) ? status_word : 32'h0000_0000;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end

  // R1: digital speed when select is one
  // R2: pin speed when select is zero
  // R3: field 30..16 as command
  wire [SPEED_WIDTH-1:0] next_speed = act.speed_source_select ?
    SPEED_WIDTH'(act.velocity_command_field) : pin_speed;

  wire is_align = (startup_method == START_ALIGN) || (startup_method == START_DOUBLE_ALIGN);
  // R5: align hold
  wire next_hold_align = act.hold_align && is_align;
  // R6: slow first cycle hold
  wire next_hold_slow = act.hold_slow_first && (startup_method == START_SLOW_FIRST);
  // R7: position detect hold
  wire next_hold_pos = act.hold_position_detect && (startup_method == START_POSITION_DETECT);
  // R8: speed detect hold
  wire next_hold_spd = act.hold_speed_detect && initial_speed_detect_enable;

  // R13: reduce modulo 360; 9-bit value is below 720
  wire [ANGLE_W-1:0] forced_mod = (forced_angle_act >= DEG_FULL) ?
    forced_angle_act - DEG_FULL : forced_angle_act;
  // R9: align angle source
  wire [ANGLE_W-1:0] next_angle = act.align_angle_source ? forced_mod : cfg_align_angle;

  // R10: sign and magnitude; 500..512 gap yields zero
  wire [IQ_W-1:0] code = act.torque_current_ref_code;
  wire code_neg = code > IQ_NEG_BASE;
  wire [IQ_W-1:0] next_mag = code_neg ? code - IQ_NEG_BASE : (code < IQ_POS_LIMIT ? code : '0);

  // Outputs registered so the control path sees stable values per cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      speed_command <= '0;
      feedback_off <= 1'b0;
      hold_align_state <= 1'b0;
      hold_slow_state <= 1'b0;
      hold_position_state <= 1'b0;
      hold_speed_state <= 1'b0;
      align_angle <= '0;
      torque_ref_valid <= 1'b0;
      torque_ref <= '0;
    end else if (ce) begin
      speed_command <= next_speed;
      // R4: open loop when set
      feedback_off <= act.feedback_control_off;
      hold_align_state <= next_hold_align;
      hold_slow_state <= next_hold_slow;
      hold_position_state <= next_hold_pos;
      hold_speed_state <= next_hold_spd;
      align_angle <= next_angle;
      // R10: forced only while velocity loop off
      torque_ref_valid <= velocity_loop_off;
      torque_ref <= velocity_loop_off ? torque_ref_s'({code_neg, next_mag}) : '0;
    end
  end

  // R12: zero after reset
  property p_reset_zero;
    @(posedge mclk)
      $fell(rst) |-> ovr == speed_source_select_s'(RST_ALGO_DEBUG_SPEED_SOURCE_SELECT) && act == ovr && rdata == 32'h0000_0000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset"); // R12

  property p_speed_sel;
    @(posedge mclk) disable iff (rst)
      ce && act.speed_source_select |=> speed_command == SPEED_WIDTH'($past(act.velocity_command_field));
  endproperty
  a_speed_sel: assert property (p_speed_sel) else $error("digital speed not applied"); // R1

  property p_speed_pin;
    @(posedge mclk) disable iff (rst)
      ce && !act.speed_source_select |=> speed_command == $past(pin_speed);
  endproperty
  a_speed_pin: assert property (p_speed_pin) else $error("pin speed not applied"); // R2

  property p_feedback;
    @(posedge mclk) disable iff (rst) ce |=> feedback_off == $past(act.feedback_control_off);
  endproperty
  a_feedback: assert property (p_feedback) else $error("open loop flag wrong"); // R4

  property p_hold_align;
    @(posedge mclk) disable iff (rst)
      ce && act.hold_align && startup_method == START_DOUBLE_ALIGN |=> hold_align_state;
  endproperty
  a_hold_align: assert property (p_hold_align) else $error("align hold missing"); // R5

  property p_hold_slow;
    @(posedge mclk) disable iff (rst)
      ce && startup_method != START_SLOW_FIRST |=> !hold_slow_state;
  endproperty
  a_hold_slow: assert property (p_hold_slow) else $error("slow hold wrong method"); // R6

  property p_hold_pos;
    @(posedge mclk) disable iff (rst)
      ce && act.hold_position_detect && startup_method == START_POSITION_DETECT |=> hold_position_state;
  endproperty
  a_hold_pos: assert property (p_hold_pos) else $error("position hold missing"); // R7

  property p_hold_spd;
    @(posedge mclk) disable iff (rst)
      ce |=> hold_speed_state == ($past(act.hold_speed_detect) && $past(initial_speed_detect_enable));
  endproperty
  a_hold_spd: assert property (p_hold_spd) else $error("speed detect hold wrong"); // R8

  property p_angle;
    @(posedge mclk) disable iff (rst)
      ce && !act.align_angle_source |=> align_angle == $past(cfg_align_angle);
  endproperty
  a_angle: assert property (p_angle) else $error("configured angle not used"); // R9

  property p_angle_mod;
    @(posedge mclk) disable iff (rst) ce && act.align_angle_source |=> align_angle < DEG_FULL;
  endproperty
  a_angle_mod: assert property (p_angle_mod) else $error("angle not below 360"); // R13

  property p_iq_neg;
    @(posedge mclk) disable iff (rst)
      ce && velocity_loop_off && code == 10'h3E8 |=> torque_ref.iq_negative && torque_ref.iq_magnitude == 10'h1E8;
  endproperty
  a_iq_neg: assert property (p_iq_neg) else $error("negative torque mapping wrong"); // R10

  property p_write_only;
    @(posedge mclk) disable iff (rst)
      ce && rd && addr == OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT |=> rdata == 32'h0000_0000;
  endproperty
  a_write_only: assert property (p_write_only) else $error("speed_source_select register readable"); // R12

  property p_update;
    @(posedge mclk) disable iff (rst) ce && ctrl_update |=> act == $past(ovr);
  endproperty
  a_update: assert property (p_update) else $error("update not sampled"); // R14

  // R12: write lands whole
  property p_write_store;
    @(posedge mclk) disable iff (rst)
      ce && wr && addr == OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT |=> ovr == speed_source_select_s'($past(wdata));
  endproperty
  a_write_store: assert property (p_write_store) else $error("speed_source_select write lost"); // R12

  // R13: angle field stored
  property p_angle_store;
    @(posedge mclk) disable iff (rst)
      ce && wr && addr == OFS_DEVICE_ANGLE |=> forced_angle == ANGLE_W'($past(wdata) >> POS_ANGLE_LSB);
  endproperty
  a_angle_store: assert property (p_angle_store) else $error("forced angle write lost"); // R13

  // R14: settings wait for update
  property p_wait_update;
    @(posedge mclk) disable iff (rst)
      ce && !ctrl_update |=> $stable(act) && $stable(forced_angle_act);
  endproperty
  a_wait_update: assert property (p_wait_update) else $error("active set changed without update"); // R14

  // R14: enable low freezes settings
  property p_freeze_state;
    @(posedge mclk) disable iff (rst)
      !ce |=> $stable(ovr) && $stable(act) && $stable(forced_angle);
  endproperty
  a_freeze_state: assert property (p_freeze_state) else $error("settings moved while disabled"); // R14

  // R14: enable low freezes outputs
  property p_freeze_out;
    @(posedge mclk) disable iff (rst)
      !ce |=> $stable(speed_command) && $stable(align_angle) && $stable(torque_ref) && $stable(rdata);
  endproperty
  a_freeze_out: assert property (p_freeze_out) else $error("outputs moved while disabled"); // R14

  // R5: single align held
  property p_hold_align_one;
    @(posedge mclk) disable iff (rst)
      ce && act.hold_align && startup_method == START_ALIGN |=> hold_align_state;
  endproperty
  a_hold_align_one: assert property (p_hold_align_one) else $error("single align hold missing"); // R5

  // R5: align released
  property p_align_release;
    @(posedge mclk) disable iff (rst)
      ce && !act.hold_align |=> !hold_align_state;
  endproperty
  a_align_release: assert property (p_align_release) else $error("align hold without request"); // R5

  // R6: slow cycle held
  property p_hold_slow_on;
    @(posedge mclk) disable iff (rst)
      ce && act.hold_slow_first && startup_method == START_SLOW_FIRST |=> hold_slow_state;
  endproperty
  a_hold_slow_on: assert property (p_hold_slow_on) else $error("slow hold missing"); // R6

  // R6: slow cycle released
  property p_slow_release;
    @(posedge mclk) disable iff (rst)
      ce && !act.hold_slow_first |=> !hold_slow_state;
  endproperty
  a_slow_release: assert property (p_slow_release) else $error("slow hold without request"); // R6

  // R7: position detect released
  property p_pos_release;
    @(posedge mclk) disable iff (rst)
      ce && (!act.hold_position_detect || startup_method != START_POSITION_DETECT) |=> !hold_position_state;
  endproperty
  a_pos_release: assert property (p_pos_release) else $error("position hold without request"); // R7

  // R9: forced angle taken
  property p_angle_forced;
    @(posedge mclk) disable iff (rst)
      ce && act.align_angle_source && forced_angle_act < DEG_FULL |=> align_angle == $past(forced_angle_act);
  endproperty
  a_angle_forced: assert property (p_angle_forced) else $error("forced angle not used"); // R9

  // R13: angle wraps at 360
  property p_angle_wrap;
    @(posedge mclk) disable iff (rst)
      ce && act.align_angle_source && forced_angle_act >= DEG_FULL |=>
        align_angle == ANGLE_W'($past(forced_angle_act) - DEG_FULL);
  endproperty
  a_angle_wrap: assert property (p_angle_wrap) else $error("forced angle not wrapped"); // R13

  // R10: no torque while loop on
  property p_iq_off;
    @(posedge mclk) disable iff (rst)
      ce && !velocity_loop_off |=> !torque_ref_valid && torque_ref == '0;
  endproperty
  a_iq_off: assert property (p_iq_off) else $error("torque forced with loop on"); // R10

  // R10: positive codes pass
  property p_iq_pos;
    @(posedge mclk) disable iff (rst)
      ce && velocity_loop_off && code < IQ_POS_LIMIT |=>
        !torque_ref.iq_negative && torque_ref.iq_magnitude == $past(code);
  endproperty
  a_iq_pos: assert property (p_iq_pos) else $error("positive torque mapping wrong"); // R10

  // R10: gap codes give zero
  property p_iq_gap;
    @(posedge mclk) disable iff (rst)
      ce && velocity_loop_off && code >= IQ_POS_LIMIT && code <= IQ_NEG_BASE |=> torque_ref == '0;
  endproperty
  a_iq_gap: assert property (p_iq_gap) else $error("gap code not zero"); // R10

  // R10: negative codes offset
  property p_iq_neg_any;
    @(posedge mclk) disable iff (rst)
      ce && velocity_loop_off && code > IQ_NEG_BASE |=>
        torque_ref.iq_negative && torque_ref.iq_magnitude == IQ_W'($past(code) - IQ_NEG_BASE);
  endproperty
  a_iq_neg_any: assert property (p_iq_neg_any) else $error("negative torque offset wrong"); // R10

  // R12: idle read data zero
  property p_rd_idle;
    @(posedge mclk) disable iff (rst)
      ce && !rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle"); // R12
endmodule

//--- dv/algo_debug_speed_source_select_reg_test.sv
// Self-checking bench for the algorithm debug speed_source_select register
module algo_debug_speed_source_select_reg_test import algo_debug_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, ce, wr, rd, ctrl_update, spd_det_en, vloop_off;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [SPEED_W-1:0] pin_speed, speed_command;
  logic [ANGLE_W-1:0] cfg_angle, align_angle;
  startup_method_e method;
  logic fb_off, h_align, h_slow, h_pos, h_spd, iq_valid;
  torque_ref_s tq_ref;
  int errors, n_tests;
  startup_method_e methods[4] = '{START_ALIGN, START_DOUBLE_ALIGN, START_SLOW_FIRST, START_POSITION_DETECT};
  int codes[6] = '{0, 499, 500, 512, 513, 1000};
  logic [10:0] iq_exp[6] = '{11'h000, 11'h1F3, 11'h000, 11'h000, 11'h401, 11'h5E8};
  int angs[3] = '{400, 359, 360};
  int ang_exp[3] = '{40, 359, 0};

  algo_debug_speed_source_select_reg u_dut (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ctrl_update(ctrl_update), .pin_speed(pin_speed), .cfg_align_angle(cfg_angle),
    .startup_method(method), .initial_speed_detect_enable(spd_det_en), .velocity_loop_off(vloop_off),
    .speed_command(speed_command), .feedback_off(fb_off), .hold_align_state(h_align), .hold_slow_state(h_slow),
    .hold_position_state(h_pos), .hold_speed_state(h_spd), .align_angle(align_angle), .torque_ref_valid(iq_valid),
    .torque_ref(tq_ref));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] mask, input logic [31:0] exp,
                        input string what);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata & mask);
  endtask

  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic upd;
    @(posedge mclk);
    ctrl_update <= 1'b1;
    @(posedge mclk);
    ctrl_update <= 1'b0;
    settle();
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    ctrl_update = 1'b0;
    addr = '0;
    wdata = '0;
    pin_speed = '0;
    cfg_angle = '0;
    method = START_ALIGN;
    spd_det_en = 1'b1;
    vloop_off = 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    settle();
    chk("hold outputs after reset", 32'h0000_0000, {h_align, h_slow, h_pos, h_spd, fb_off});
    chk("speed after reset", 32'h0000_0000, speed_command);
    rd_chk(OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT, 32'hFFFF_FFFF, 32'h0000_0000, "speed_source_select readback");
    rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    $display("test reset done");
    // Written settings must wait for the control update
    @(posedge mclk);
    pin_speed <= 15'h0055;
    wr_reg(OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT, 32'h9234_F800);
    settle();
    chk("speed before update", 32'h0000_0055, speed_command);
    chk("open loop before update", 32'h0000_0000, fb_off);
    upd();
    chk("digital speed", 32'h0000_1234, speed_command);
    chk("open loop", 32'h0000_0001, fb_off);
    rd_chk(OFS_SPEED_SOURCE_SELECT_STATUS, 32'h0000_0100, 32'h0000_0100, "status speed source");
    foreach (methods[i]) begin
      @(posedge mclk);
      method <= methods[i];
      settle();
      chk("hold align", 32'(i < 2), h_align);
      chk("hold slow", 32'(i == 2), h_slow);
      chk("hold position", 32'(i == 3), h_pos);
    end
    chk("hold speed detect on", 32'h0000_0001, h_spd);
    @(posedge mclk);
    spd_det_en <= 1'b0;
    settle();
    chk("hold speed detect off", 32'h0000_0000, h_spd);
    $display("test speed_source_select done");
    // Clock enable low must swallow both the write and the update
    @(posedge mclk);
    ce <= 1'b0;
    wr_reg(OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT, 32'h0000_0000);
    upd();
    @(posedge mclk);
    ce <= 1'b1;
    settle();
    chk("speed frozen", 32'h0000_1234, speed_command);
    chk("open loop frozen", 32'h0000_0001, fb_off);
    $display("test enable done");
    @(posedge mclk);
    spd_det_en <= 1'b1;
    method <= START_ALIGN;
    wr_reg(OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT, 32'h0000_0000);
    upd();
    chk("pin speed", 32'h0000_0055, speed_command);
    chk("closed loop", 32'h0000_0000, {h_align, h_spd, fb_off});
    chk("torque not forced", 32'h0000_0000, {iq_valid, tq_ref});
    $display("test release done");
    @(posedge mclk);
    cfg_angle <= 9'h0AB;
    foreach (angs[i]) begin
      wr_reg(OFS_DEVICE_ANGLE, 32'(angs[i]) << 11);
      wr_reg(OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT, 32'h0000_0400);
      upd();
      chk("forced angle", 32'(ang_exp[i]), align_angle);
    end
    rd_chk(OFS_SPEED_SOURCE_SELECT_STATUS, 32'h0000_0004, 32'h0000_0004, "status angle source");
    wr_reg(OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT, 32'h0000_0000);
    upd();
    chk("configured angle", 32'h0000_00AB, align_angle);
    $display("test angle done");
    @(posedge mclk);
    vloop_off <= 1'b1;
    // Codes stay in the legal ranges only
    foreach (codes[i]) begin
      wr_reg(OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT, 32'(codes[i]));
      upd();
      chk("torque valid", 32'h0000_0001, iq_valid);
      chk("torque reference", 32'(iq_exp[i]), tq_ref);
    end
    $display("test torque done");
    close_out();
  end
endmodule

//--- pkg/algo_debug_pkg.sv
// Package for the algorithm debug speed_source_select register bank
package algo_debug_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_ALGO_DEBUG_SPEED_SOURCE_SELECT = 8'hEC;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_ANGLE = 8'hEA;
  localparam logic [ADDR_W-1:0] OFS_SPEED_SOURCE_SELECT_STATUS = 8'hF8;
  localparam logic [31:0] RST_ALGO_DEBUG_SPEED_SOURCE_SELECT = 32'h0000_0000;
  localparam int POS_SPEED_SRC = 31;
  localparam int POS_SPEED_LSB = 16;
  localparam int POS_FB_OFF = 15;
  localparam int POS_HOLD_ALIGN = 14;
  localparam int POS_HOLD_SLOW = 13;
  localparam int POS_HOLD_IPD = 12;
  localparam int POS_HOLD_ISD = 11;
  localparam int POS_ANGLE_SRC = 10;
  localparam int POS_ANGLE_LSB = 11;
  localparam int SPEED_W = 15;
  localparam int IQ_W = 10;
  localparam int ANGLE_W = 9;
  localparam logic [IQ_W-1:0] IQ_POS_LIMIT = 10'h1F4;
  localparam logic [IQ_W-1:0] IQ_NEG_BASE = 10'h200;
  localparam logic [ANGLE_W-1:0] DEG_FULL = 9'h168;

  typedef enum logic [2:0] {
    START_ALIGN, START_DOUBLE_ALIGN, START_SLOW_FIRST, START_POSITION_DETECT
  } startup_method_e;

  typedef struct packed {
    logic speed_source_select;
    logic [SPEED_W-1:0] velocity_command_field;
    logic feedback_control_off;
    logic hold_align;
    logic hold_slow_first;
    logic hold_position_detect;
    logic hold_speed_detect;
    logic align_angle_source;
    logic [IQ_W-1:0] torque_current_ref_code;
  } speed_source_select_s;

  typedef struct packed {
    logic iq_negative;
    logic [IQ_W-1:0] iq_magnitude;
  } torque_ref_s;
endpackage
